// ===== hdl/fcp_host.sv
/*
 Host that runs flash command, read and page-load cycles on the pins.
 Assumes pins synchronous to sys_clk_i and a pad steered by dq_oe_o.
*/
// Functional notes
// R1 - Protect/unprotect: six writes, final 20H/40H
// R2 - Verify: unlock, 90H, read sector code
// R3 - Unlock addresses use bits 0 to 14
// R4 - Only low data byte carries commands
// R5 - Sector chosen by address bits 15-19
// R6 - Protection only for lowest or highest sector
// R7 - Address captured at chip select fall
// R8 - Identification code chosen by address bit 0
// R9 - Leave identification mode by read/reset
// R10 - Device powers up in read array
// R11 - After read/reset, reads return array data
// R12 - Outputs driven only when both selects low
// R13 - Read/reset ignored while programming
// R14 - Program prefix: AAH, 55H, A0H
// R15 - No load without full program prefix
// R16 - Data captured at chip select rise
// R17 - Page holds at most 64 words
// R18 - Unloaded words stay erased
// R19 - Next load within 30us of rise
// R20 - Page bits fixed, words any order
// R21 - Programming starts 100us after last load
// R22 - Completion on status bit seven
// R23 - Only status reads while sequencer busy
// R24 - Abort: unlock then E0H
`include "fcp_map.svh"

module fcp_host #(
   parameter int PRG_START_CYC = `FCP_PRG_START_CYC,
   parameter int POLL_MAX = 50000
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Command port
   input wire logic cmd_valid_i,
   input wire fcp_pkg::fcp_op_t cmd_op_i,
   input wire logic [19:0] cmd_addr_i,
   output logic cmd_ready_o,
   output logic done_o,
   output logic err_o,
   output logic [15:0] rd_data_o,
   // Page word stream
   input wire logic wr_valid_i,
   input wire logic [5:0] wr_off_i,
   input wire logic [15:0] wr_data_i,
   output logic wr_ready_o,
   // Flash pins
   output logic ce_n_o,
   output logic oe_n_o,
   output logic [19:0] addr_o,
   output logic [15:0] dq_o,
   output logic dq_oe_o,
   input wire logic [15:0] dq_i
);

   fcp_pkg::fcp_state_t state_ff, nxt_state;
   fcp_pkg::fcp_op_t op_ff, nxt_op;
   logic [2:0] step_ff, nxt_step;
   logic [15:0] cnt_ff, nxt_cnt;
   logic [15:0] gap_ff, nxt_gap;
   logic [15:0] poll_ff, nxt_poll;
   logic [19:0] arg_ff, nxt_arg;
   logic [6:0] word_cnt_ff, nxt_word_cnt;
   logic loading_ff, nxt_loading;
   logic polling_ff, nxt_polling;
   logic ce_n_ff, nxt_ce_n;
   logic oe_n_ff, nxt_oe_n;
   logic [19:0] addr_ff, nxt_addr;
   logic [15:0] dq_ff, nxt_dq;
   logic dq_oe_ff, nxt_dq_oe;
   logic ready_ff, nxt_ready;
   logic done_ff, nxt_done;
   logic err_ff, nxt_err;
   logic [15:0] rdata_ff, nxt_rdata;
   logic buf_valid, buf_pop;
   logic [21:0] buf_data;
   logic [27:0] seq;
   logic [2:0] last_step;

   // ==========================================================
   // Word buffer
   fcp_buf2 #(.W(22)) u_buf (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(wr_valid_i),
      .in_data_i({wr_off_i, wr_data_i}),
      .in_ready_o(wr_ready_o),
      .out_valid_o(buf_valid),
      .out_data_o(buf_data),
      .out_ready_i(buf_pop)
   );

   // ==========================================================
   // Command sequence table
   function automatic logic [7:0] third_code(fcp_pkg::fcp_op_t op);
      case (op)
         fcp_pkg::FCP_OP_ID: third_code = `FCP_CMD_ID;
         fcp_pkg::FCP_OP_PROTECT: third_code = `FCP_CMD_PROT_SETUP;
         fcp_pkg::FCP_OP_UNPROTECT: third_code = `FCP_CMD_PROT_SETUP;
         fcp_pkg::FCP_OP_VERIFY: third_code = `FCP_CMD_VERIFY;
         fcp_pkg::FCP_OP_ABORT: third_code = `FCP_CMD_ABORT; // see R24
         fcp_pkg::FCP_OP_PROGRAM: third_code = `FCP_CMD_PROGRAM; // see R14
         fcp_pkg::FCP_OP_STATUS: third_code = `FCP_CMD_STATUS;
         default: third_code = `FCP_CMD_RESET;
      endcase
   endfunction : third_code

   function automatic logic [27:0] seq_word(fcp_pkg::fcp_op_t op,
                                            logic [2:0] step,
                                            logic [19:0] arg);
      logic [7:0] fin;
      fin = (op == fcp_pkg::FCP_OP_PROTECT) ? `FCP_CMD_PROTECT
                                            : `FCP_CMD_UNPROTECT; // see R1
      case (step)
         3'h0: seq_word = {`FCP_UNLOCK_ADDR1, `FCP_UNLOCK_DATA1}; // see R3
         3'h1: seq_word = {`FCP_UNLOCK_ADDR2, `FCP_UNLOCK_DATA2};
         3'h2: seq_word = {`FCP_UNLOCK_ADDR1, third_code(op)};
         3'h3: seq_word = {`FCP_UNLOCK_ADDR1, `FCP_UNLOCK_DATA1};
         3'h4: seq_word = {`FCP_UNLOCK_ADDR2, `FCP_UNLOCK_DATA2};
         default: seq_word = {arg[19:`FCP_SECT_LSB], 15'h0000, fin}; // see R5
      endcase
   endfunction : seq_word

   // ==========================================================
   // Sequencer next values
   always_comb
   begin
      nxt_state = state_ff;
      nxt_op = op_ff;
      nxt_step = step_ff;
      nxt_cnt = cnt_ff;
      nxt_gap = gap_ff;
      nxt_poll = poll_ff;
      nxt_arg = arg_ff;
      nxt_word_cnt = word_cnt_ff;
      nxt_loading = loading_ff;
      nxt_polling = polling_ff;
      nxt_ce_n = ce_n_ff;
      nxt_oe_n = oe_n_ff;
      nxt_addr = addr_ff;
      nxt_dq = dq_ff;
      nxt_dq_oe = dq_oe_ff;
      nxt_ready = ready_ff;
      nxt_done = 1'b0;
      nxt_err = err_ff;
      nxt_rdata = rdata_ff;
      buf_pop = 1'b0;
      last_step = (op_ff == fcp_pkg::FCP_OP_PROTECT ||
                   op_ff == fcp_pkg::FCP_OP_UNPROTECT) ? `FCP_STEPS_LONG
                                                       : `FCP_STEPS_SHORT;
      seq = seq_word(op_ff, step_ff + 3'h1, arg_ff);
      case (state_ff)
         fcp_pkg::ST_IDLE:
         begin
            if (cmd_valid_i && ready_ff) // see R23, R13
            begin
               nxt_op = cmd_op_i;
               nxt_arg = cmd_addr_i;
               nxt_ready = 1'b0;
               nxt_err = 1'b0;
               nxt_step = 3'h0;
               nxt_loading = 1'b0;
               nxt_polling = 1'b0;
               nxt_word_cnt = 7'h00;
               seq = seq_word(cmd_op_i, 3'h0, cmd_addr_i);
               if (cmd_op_i == fcp_pkg::FCP_OP_READ) // see R10, R11
               begin
                  nxt_addr = cmd_addr_i;
                  nxt_state = fcp_pkg::ST_RSET;
               end
               else if ((cmd_op_i == fcp_pkg::FCP_OP_PROTECT ||
                         cmd_op_i == fcp_pkg::FCP_OP_UNPROTECT) &&
                        cmd_addr_i[19:15] != `FCP_SECT_LOW &&
                        cmd_addr_i[19:15] != `FCP_SECT_HIGH) // see R6
               begin
                  nxt_err = 1'b1;
                  nxt_state = fcp_pkg::ST_DONE;
               end
               else
               begin
                  nxt_addr = seq[27:8];
                  nxt_dq = {`FCP_HIGH_BYTE, seq[7:0]}; // see R4
                  nxt_dq_oe = 1'b1;
                  nxt_state = fcp_pkg::ST_WSET;
               end
            end
         end
         fcp_pkg::ST_WSET:
         begin
            nxt_ce_n = 1'b0; // see R7
            nxt_cnt = 16'h0000;
            nxt_state = fcp_pkg::ST_WLOW;
         end
         fcp_pkg::ST_WLOW:
         begin
            if (cnt_ff == 16'(`FCP_WR_PULSE_CYC - 1))
            begin
               nxt_ce_n = 1'b1;
               nxt_state = fcp_pkg::ST_WREC;
            end
            else
               nxt_cnt = cnt_ff + 16'h0001;
         end
         fcp_pkg::ST_WREC:
         begin
            // Data held through the rising edge, released after unless another command write follows
            nxt_dq_oe = 1'b0; // see R16
            if (loading_ff)
            begin
               nxt_gap = 16'h0001;
               nxt_word_cnt = word_cnt_ff + 7'h01;
               nxt_state = fcp_pkg::ST_LOAD;
            end
            else if (step_ff + 3'h1 == last_step)
            begin
               case (op_ff)
                  fcp_pkg::FCP_OP_PROGRAM:
                  begin
                     nxt_loading = 1'b1;
                     nxt_gap = 16'h0000;
                     nxt_state = fcp_pkg::ST_LOAD;
                  end
                  fcp_pkg::FCP_OP_RESET:
                  begin
                     nxt_addr = arg_ff;
                     nxt_state = fcp_pkg::ST_RSET;
                  end
                  fcp_pkg::FCP_OP_ID:
                  begin
                     nxt_addr = {18'h00000, 1'b0, arg_ff[0]}; // see R8, R9
                     nxt_state = fcp_pkg::ST_RSET;
                  end
                  fcp_pkg::FCP_OP_VERIFY:
                  begin
                     nxt_addr = {arg_ff[19:15], 13'h0000, 2'h2}; // see R2
                     nxt_state = fcp_pkg::ST_RSET;
                  end
                  fcp_pkg::FCP_OP_STATUS:
                  begin
                     nxt_addr = 20'h00000;
                     nxt_state = fcp_pkg::ST_RSET;
                  end
                  default: nxt_state = fcp_pkg::ST_DONE;
               endcase
            end
            else
            begin
               nxt_step = step_ff + 3'h1;
               nxt_addr = seq[27:8];
               nxt_dq = {`FCP_HIGH_BYTE, seq[7:0]};
               nxt_dq_oe = 1'b1;
               nxt_state = fcp_pkg::ST_WSET;
            end
         end
         fcp_pkg::ST_LOAD:
         begin
            if (gap_ff != 16'hffff)
               nxt_gap = gap_ff + 16'h0001;
            if (word_cnt_ff == `FCP_PAGE_WORDS) // see R17
            begin
               nxt_loading = 1'b0;
               nxt_cnt = 16'h0000;
               nxt_state = fcp_pkg::ST_PWAIT;
            end
            else if (buf_valid &&
                     gap_ff < 16'(`FCP_LOAD_GAP_CYC - 2)) // see R19
            begin
               buf_pop = 1'b1;
               nxt_addr = {arg_ff[19:`FCP_PAGE_LSB], buf_data[21:16]}; // see R20
               nxt_dq = buf_data[15:0];
               nxt_dq_oe = 1'b1;
               nxt_state = fcp_pkg::ST_WSET;
            end
            else if (gap_ff >= 16'(`FCP_LOAD_GAP_CYC - 2))
            begin
               nxt_loading = 1'b0;
               nxt_cnt = 16'h0000;
               nxt_state = fcp_pkg::ST_PWAIT;
            end
         end
         fcp_pkg::ST_PWAIT:
         begin
            if (cnt_ff == 16'(PRG_START_CYC - 1)) // see R21
            begin
               nxt_polling = 1'b1;
               nxt_poll = 16'h0000;
               nxt_addr = 20'h00000;
               nxt_state = fcp_pkg::ST_RSET;
            end
            else
               nxt_cnt = cnt_ff + 16'h0001;
         end
         fcp_pkg::ST_RSET:
         begin
            nxt_ce_n = 1'b0; // see R12
            nxt_oe_n = 1'b0;
            nxt_cnt = 16'h0000;
            nxt_state = fcp_pkg::ST_RLOW;
         end
         fcp_pkg::ST_RLOW:
         begin
            if (cnt_ff == 16'(`FCP_RD_ACCESS_CYC - 1))
            begin
               nxt_rdata = dq_i;
               nxt_ce_n = 1'b1;
               nxt_oe_n = 1'b1;
               nxt_state = fcp_pkg::ST_DONE;
               if (polling_ff && !dq_i[`FCP_DONE_BIT]) // see R22
               begin
                  if (poll_ff == 16'(POLL_MAX - 1))
                     nxt_err = 1'b1;
                  else
                  begin
                     nxt_poll = poll_ff + 16'h0001;
                     nxt_state = fcp_pkg::ST_RSET;
                  end
               end
            end
            else
               nxt_cnt = cnt_ff + 16'h0001;
         end
         fcp_pkg::ST_DONE:
         begin
            nxt_done = 1'b1;
            nxt_ready = 1'b1;
            nxt_polling = 1'b0;
            nxt_state = fcp_pkg::ST_IDLE;
         end
         default: nxt_state = fcp_pkg::ST_IDLE;
      endcase
   end

   // ==========================================================
   // Sequencer registers
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         state_ff <= fcp_pkg::ST_IDLE;
         op_ff <= fcp_pkg::FCP_OP_READ;
         step_ff <= 3'h0;
         cnt_ff <= 16'h0000;
         gap_ff <= 16'h0000;
         poll_ff <= 16'h0000;
         arg_ff <= 20'h00000;
         word_cnt_ff <= 7'h00;
         loading_ff <= 1'b0;
         polling_ff <= 1'b0;
         ce_n_ff <= 1'b1;
         oe_n_ff <= 1'b1;
         addr_ff <= 20'h00000;
         dq_ff <= 16'h0000;
         dq_oe_ff <= 1'b0;
         ready_ff <= 1'b1;
         done_ff <= 1'b0;
         err_ff <= 1'b0;
         rdata_ff <= 16'h0000;
      end
      else
      begin
         state_ff <= nxt_state;
         op_ff <= nxt_op;
         step_ff <= nxt_step;
         cnt_ff <= nxt_cnt;
         gap_ff <= nxt_gap;
         poll_ff <= nxt_poll;
         arg_ff <= nxt_arg;
         word_cnt_ff <= nxt_word_cnt;
         loading_ff <= nxt_loading;
         polling_ff <= nxt_polling;
         ce_n_ff <= nxt_ce_n;
         oe_n_ff <= nxt_oe_n;
         addr_ff <= nxt_addr;
         dq_ff <= nxt_dq;
         dq_oe_ff <= nxt_dq_oe;
         ready_ff <= nxt_ready;
         done_ff <= nxt_done;
         err_ff <= nxt_err;
         rdata_ff <= nxt_rdata;
      end
   end

   assign cmd_ready_o = ready_ff;
   assign done_o = done_ff;
   assign err_o = err_ff;
   assign rd_data_o = rdata_ff;
   assign ce_n_o = ce_n_ff;
   assign oe_n_o = oe_n_ff;
   assign addr_o = addr_ff;
   assign dq_o = dq_ff;
   assign dq_oe_o = dq_oe_ff;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   a_no_contention: assert property (dq_oe_o |-> oe_n_o) // see R12
      else $error("data driven while output gate low");
   a_unlock_first: assert property ( // see R3
      (state_ff == fcp_pkg::ST_WLOW && !loading_ff && step_ff == 3'h0)
      |-> addr_o == `FCP_UNLOCK_ADDR1 && dq_o[7:0] == `FCP_UNLOCK_DATA1)
      else $error("first unlock write wrong");
   a_high_byte_zero: assert property ( // see R4
      (state_ff == fcp_pkg::ST_WLOW && !loading_ff)
      |-> dq_o[15:8] == `FCP_HIGH_BYTE)
      else $error("command high byte not zero");
   a_prot_final: assert property ( // see R1
      (state_ff == fcp_pkg::ST_WLOW && step_ff == 3'h5)
      |-> dq_o[7:0] == ((op_ff == fcp_pkg::FCP_OP_PROTECT) ?
                        `FCP_CMD_PROTECT : `FCP_CMD_UNPROTECT))
      else $error("protect final code wrong");
   a_sector_edge: assert property ( // see R6
      (state_ff == fcp_pkg::ST_WLOW && step_ff == 3'h5)
      |-> addr_o[19:15] inside {`FCP_SECT_LOW, `FCP_SECT_HIGH})
      else $error("protect sector not edge sector");
   a_addr_hold: assert property ( // see R7
      $fell(ce_n_o) |-> $stable(addr_o) [*4])
      else $error("address moved during select");
   a_data_hold: assert property ( // see R16
      ($rose(ce_n_o) && $past(dq_oe_o)) |-> dq_oe_o && $stable(dq_o))
      else $error("data not held at select rise");
   a_prog_code: assert property ( // see R14
      (state_ff == fcp_pkg::ST_WLOW && !loading_ff && step_ff == 3'h2 &&
       op_ff == fcp_pkg::FCP_OP_PROGRAM) |-> dq_o[7:0] == `FCP_CMD_PROGRAM)
      else $error("program code wrong");
   a_load_prefix: assert property ( // see R15
      ($fell(ce_n_o) && loading_ff)
      |-> op_ff == fcp_pkg::FCP_OP_PROGRAM && oe_n_o)
      else $error("load without program prefix");
   a_page_fixed: assert property ( // see R20
      ($fell(ce_n_o) && loading_ff)
      |-> addr_o[19:6] == arg_ff[19:6])
      else $error("page address changed");
   a_word_limit: assert property ( // see R17
      word_cnt_ff <= `FCP_PAGE_WORDS)
      else $error("page overfilled");
   a_load_gap: assert property ( // see R19
      (state_ff == fcp_pkg::ST_LOAD) |-> gap_ff < 16'(`FCP_LOAD_GAP_CYC))
      else $error("load gap exceeded");
   a_done_pulse: assert property (done_o |-> cmd_ready_o ##1 !done_o)
      else $error("done not a single pulse");

   c_program: cover property (done_o && op_ff == fcp_pkg::FCP_OP_PROGRAM);
   c_protect: cover property (done_o && op_ff == fcp_pkg::FCP_OP_PROTECT);
   c_verify: cover property (done_o && op_ff == fcp_pkg::FCP_OP_VERIFY);
   c_load: cover property ($fell(ce_n_o) && loading_ff);

endmodule : fcp_host

// ===== hdl/fcp_map.svh
/*
 Constants of the flash command host: command codes, unlock addresses,
 field positions and timing counts. Assumes a 50 MHz host clock.
*/
`ifndef FCP_MAP_SVH
`define FCP_MAP_SVH

// ==========================================================
// Unlock and command codes
`define FCP_UNLOCK_ADDR1 20'h05555
`define FCP_UNLOCK_ADDR2 20'h02aaa
`define FCP_UNLOCK_DATA1 8'haa
`define FCP_UNLOCK_DATA2 8'h55
`define FCP_CMD_RESET 8'hf0
`define FCP_CMD_ID 8'h90
`define FCP_CMD_PROGRAM 8'ha0
`define FCP_CMD_PROT_SETUP 8'h60
`define FCP_CMD_PROTECT 8'h20
`define FCP_CMD_UNPROTECT 8'h40
`define FCP_CMD_VERIFY 8'h90
`define FCP_CMD_ABORT 8'he0
`define FCP_CMD_STATUS 8'h70
`define FCP_HIGH_BYTE 8'h00
`define FCP_STEPS_LONG 3'h6
`define FCP_STEPS_SHORT 3'h3

// ==========================================================
// Field positions and sizes
`define FCP_SECT_LSB 15
`define FCP_PAGE_LSB 6
`define FCP_PAGE_WORDS 7'h40
`define FCP_DONE_BIT 7
`define FCP_SECT_LOW 5'h00
`define FCP_SECT_HIGH 5'h1f

// ==========================================================
// Timing
`define FCP_CLK_MHZ 50
`define FCP_WR_PULSE_NS 100
`define FCP_RD_ACCESS_NS 120
`define FCP_LOAD_GAP_US 30
`define FCP_PRG_START_US 100
`define FCP_WR_PULSE_CYC ((`FCP_WR_PULSE_NS * `FCP_CLK_MHZ + 999) / 1000)
`define FCP_RD_ACCESS_CYC ((`FCP_RD_ACCESS_NS * `FCP_CLK_MHZ + 999) / 1000)
`define FCP_LOAD_GAP_CYC (`FCP_LOAD_GAP_US * `FCP_CLK_MHZ)
`define FCP_PRG_START_CYC (`FCP_PRG_START_US * `FCP_CLK_MHZ)

`endif

// ===== hdl/fcp_pkg.sv
/*
 Types of the flash command host: operations and controller states.
 Assumes nothing of its surroundings.
*/
package fcp_pkg;

   // ==========================================================
   // Operations
   typedef enum logic [3:0] {
      FCP_OP_READ,
      FCP_OP_RESET,
      FCP_OP_ID,
      FCP_OP_PROTECT,
      FCP_OP_UNPROTECT,
      FCP_OP_VERIFY,
      FCP_OP_ABORT,
      FCP_OP_PROGRAM,
      FCP_OP_STATUS
   } fcp_op_t;

   // ==========================================================
   // Controller states
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_WSET,
      ST_WLOW,
      ST_WREC,
      ST_LOAD,
      ST_PWAIT,
      ST_RSET,
      ST_RLOW,
      ST_DONE
   } fcp_state_t;

endpackage : fcp_pkg

// ===== hdl/fcp_buf2.sv
/*
 Two-entry buffer with valid and ready on both sides.
 Assumes one clock and an asynchronous active-high reset.
*/
module fcp_buf2 #(
   parameter int W = 22
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Fill side
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   // Drain side
   output logic out_valid_o,
   output logic [W-1:0] out_data_o,
   input wire logic out_ready_i
);

   logic [W-1:0] mem_ff [2];
   logic [W-1:0] nxt_mem [2];
   logic wptr_ff, nxt_wptr;
   logic rptr_ff, nxt_rptr;
   logic [1:0] cnt_ff, nxt_cnt;
   logic room_ff, nxt_room;
   logic push, pop;

   // ==========================================================
   // Next values
   always_comb
   begin
      push = in_valid_i && room_ff;
      pop = out_ready_i && (cnt_ff != 2'h0);
      nxt_wptr = push ? ~wptr_ff : wptr_ff;
      nxt_rptr = pop ? ~rptr_ff : rptr_ff;
      nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
      nxt_room = (nxt_cnt != 2'h2);
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_entry
         always_comb
         begin
            nxt_mem[gi] = (push && (wptr_ff == 1'(gi))) ? in_data_i
                                                       : mem_ff[gi];
         end
         always_ff @(posedge sys_clk_i or posedge sys_rst_i)
         begin
            if (sys_rst_i)
               mem_ff[gi] <= '0;
            else
               mem_ff[gi] <= nxt_mem[gi];
         end
      end
   endgenerate

   // ==========================================================
   // Pointers and fill level
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         wptr_ff <= 1'b0;
         rptr_ff <= 1'b0;
         cnt_ff <= 2'h0;
         room_ff <= 1'b1;
      end
      else
      begin
         wptr_ff <= nxt_wptr;
         rptr_ff <= nxt_rptr;
         cnt_ff <= nxt_cnt;
         room_ff <= nxt_room;
      end
   end

   assign in_ready_o = room_ff;
   assign out_valid_o = (cnt_ff != 2'h0);
   assign out_data_o = mem_ff[rptr_ff];

endmodule : fcp_buf2

// ===== dv/fcp_flash_model.sv
/*
 Behavioural flash at the far side of fcp_host.
 Assumes the host clock times its load window.
*/
module fcp_flash_model #(
   parameter int END_CYC = 1600,
   parameter logic [15:0] MAN_CODE = 16'h0012, // Arbitrary value
   parameter logic [15:0] DEV_CODE = 16'h0034 // Arbitrary value
) (
   // Clock
   input wire logic sys_clk_i,
   // Flash pins
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic [19:0] addr_i,
   input wire logic [15:0] dq_i,
   input wire logic dq_oe_i,
   output logic [15:0] dq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [logic [19:0]];
   logic [15:0] page [logic [5:0]];
   logic [19:0] a_lat;
   logic [13:0] pg = 14'h0000;
   logic [1:0] prot = 2'h0;
   logic [1:0] mode = 2'h0; // Array reads after power-up
   logic ld = 1'b0;
   logic [15:0] last = 16'h0000;
   int step = 0;
   int idle = 0;
   int busy = 0;

   // ==========================================================
   // Read path
   function automatic logic [15:0] rd(input logic [19:0] a);
      if (mode == 2'h2)
         return {8'h00, busy == 0, 7'h00};
      if (mode == 2'h1 && a[1])
         return prot[a[19]] && a[19:15] == {5{a[19]}} ? MAN_CODE : '0;
      if (mode == 2'h1)
         return a[0] ? DEV_CODE : MAN_CODE;
      return mem.exists(a) ? mem[a] : 16'hffff;
   endfunction : rd

   initial dq_o = 16'h0000;
   always @(negedge sys_clk_i)
   begin
      dq_o = (!ce_n_i && !oe_n_i) ? rd(addr_i) : ~last;
      last = dq_o;
   end

   // ==========================================================
   // Write path
   task automatic wr(input logic [19:0] a, input logic [15:0] d);
      logic [7:0] c;
      logic u1;
      c = d[7:0];
      u1 = a[14:0] == 15'h5555;
      if (busy > 0)
         return;
      if (ld)
      begin
         page[a[5:0]] = d;
         pg = a[19:6];
         idle = 0;
         return;
      end
      case (step)
         0, 3: step = (u1 && c == 8'haa) ? step + 1 : 0;
         1, 4: step = (a[14:0] == 15'h2aaa && c == 8'h55) ? step + 1 : 0;
         2: // Abort and other codes keep the mode
         begin
            step = (u1 && c == 8'h60) ? 3 : 0;
            if (u1 && c == 8'hf0)
               mode = 2'h0;
            if (u1 && c == 8'h90)
               mode = 2'h1;
            if (u1 && c == 8'h70)
               mode = 2'h2;
            ld = u1 && c == 8'ha0;
            idle = 0;
         end
         default:
         begin
            step = 0;
            if ((c == 8'h20 || c == 8'h40) && a[19:15] == {5{a[19]}})
               prot[a[19]] = c == 8'h20;
         end
      endcase
   endtask : wr

   always @(negedge ce_n_i)
      a_lat = addr_i;
   always @(posedge ce_n_i)
      if (oe_n_i && dq_oe_i)
         wr(a_lat, dq_i);
   always @(posedge sys_clk_i)
   begin
      if (busy > 0)
         busy--;
      idle = (ld && ce_n_i) ? idle + 1 : idle;
      if (ld && idle >= END_CYC)
      begin
         foreach (page[o])
            mem[{pg, o}] = page[o];
         page.delete();
         ld = 1'b0;
         busy = 4;
         mode = 2'h2;
      end
   end
endmodule : fcp_flash_model

// ===== dv/fcp_host_tb_top.sv
/*
 Self-checking bench of fcp_host with a behavioural flash.
 Assumes fcp_pkg, the host and the flash model compiled first.
*/
module fcp_host_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic cmd_valid_i = 1'b0;
   fcp_pkg::fcp_op_t cmd_op_i = fcp_pkg::FCP_OP_READ;
   logic [19:0] cmd_addr_i = 20'h00000;
   logic wr_valid_i = 1'b0;
   logic [5:0] wr_off_i = 6'h00;
   logic [15:0] wr_data_i = 16'h0000;
   logic cmd_ready_o, done_o, err_o, wr_ready_o, ce_n_o, oe_n_o, dq_oe_o;
   logic [15:0] rd_data_o, dq_o, dq_i;
   logic [19:0] addr_o;
   logic [15:0] sh [logic [5:0]];
   logic [5:0] wo [64];
   logic [15:0] wd [64];
   logic [13:0] pg;
   int mismatches = 0;
   int comparisons = 0;
   int n;

   fcp_host #(.PRG_START_CYC(1700), .POLL_MAX(8)) dut (.sys_clk_i, .sys_rst_i,
      .cmd_valid_i, .cmd_op_i, .cmd_addr_i, .cmd_ready_o, .done_o, .err_o,
      .rd_data_o, .wr_valid_i, .wr_off_i, .wr_data_i, .wr_ready_o, .ce_n_o,
      .oe_n_o, .addr_o, .dq_o, .dq_oe_o, .dq_i);
   fcp_flash_model flash (
      .sys_clk_i, .ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .addr_i(addr_o),
      .dq_i(dq_o), .dq_oe_i(dq_oe_o), .dq_o(dq_i));

   // ==========================================================
   // Tasks
   task automatic chk(input string s, input logic [15:0] e, x);
      comparisons++;
      if (x !== e)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", s, e, x);
      end
   endtask : chk

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up

   task automatic cmd(input fcp_pkg::fcp_op_t op, input logic [19:0] a,
      input logic e = 1'b0);
      int k;
      @(negedge sys_clk_i);
      cmd_valid_i = 1'b1;
      cmd_op_i = op;
      cmd_addr_i = a;
      @(negedge sys_clk_i);
      cmd_valid_i = 1'b0;
      for (k = 0; k < 4000 && done_o !== 1'b1; k++)
         @(negedge sys_clk_i);
      chk("done_err", {14'h0, 1'b1, e}, {14'h0, done_o, err_o});
   endtask : cmd

   task automatic put(input logic [5:0] o, input logic [15:0] d);
      @(negedge sys_clk_i);
      wr_valid_i = 1'b1;
      wr_off_i = o;
      wr_data_i = d;
      while (wr_ready_o !== 1'b1)
         @(negedge sys_clk_i);
      @(negedge sys_clk_i);
      wr_valid_i = 1'b0;
   endtask : put

   function automatic logic [15:0] exp_rd(input logic [5:0] o);
      return sh.exists(o) ? sh[o] : 16'hffff;
   endfunction : exp_rd

   // ==========================================================
   // Clock, watchdog and scenarios
   initial
      forever #10 sys_clk_i = ~sys_clk_i;
   initial
   begin
      repeat (60000) @(posedge sys_clk_i);
      mismatches++;
      wrap_up();
   end
   initial
   begin
      void'($urandom(89826));
      repeat (16) @(negedge sys_clk_i);
      sys_rst_i = 1'b0;
      cmd(fcp_pkg::FCP_OP_READ, 20'($urandom));
      chk("array", 16'hffff, rd_data_o);
      cmd(fcp_pkg::FCP_OP_ID, 20'h00000);
      chk("man", flash.MAN_CODE, rd_data_o);
      cmd(fcp_pkg::FCP_OP_ID, 20'h00001);
      chk("dev", flash.DEV_CODE, rd_data_o);
      cmd(fcp_pkg::FCP_OP_ABORT, 20'h00000);
      cmd(fcp_pkg::FCP_OP_READ, 20'h00001);
      chk("abort", flash.DEV_CODE, rd_data_o);
      cmd(fcp_pkg::FCP_OP_PROTECT, 20'h00000);
      cmd(fcp_pkg::FCP_OP_VERIFY, 20'h00000);
      chk("prot_lo", flash.MAN_CODE, rd_data_o);
      cmd(fcp_pkg::FCP_OP_VERIFY, 20'hf8000);
      chk("prot_hi", 16'h0000, rd_data_o);
      cmd(fcp_pkg::FCP_OP_UNPROTECT, 20'h00000);
      cmd(fcp_pkg::FCP_OP_VERIFY, 20'h00000);
      chk("unprot", 16'h0000, rd_data_o);
      cmd(fcp_pkg::FCP_OP_PROTECT, 20'h08000, 1'b1);
      for (int r = 0; r < 2; r++)
      begin
         sh.delete();
         pg = 14'($urandom);
         n = r ? 2 + $urandom % 7 : 64;
         for (int i = 0; i < n; i++)
         begin
            wo[i] = r ? 6'($urandom) : 6'(63 - i);
            wd[i] = 16'($urandom);
            sh[wo[i]] = wd[i];
         end
         put(wo[0], wd[0]);
         put(wo[1], wd[1]);
         @(negedge sys_clk_i);
         chk("full", 16'h0000, 16'(wr_ready_o));
         fork
            cmd(fcp_pkg::FCP_OP_PROGRAM, {pg, 6'h00});
            for (int i = 2; i < n; i++)
               put(wo[i], wd[i]);
         join
         chk("poll", 16'h0080, rd_data_o);
         cmd(fcp_pkg::FCP_OP_STATUS, 20'h00000);
         chk("status", 16'h0080, rd_data_o);
         cmd(fcp_pkg::FCP_OP_RESET, 20'h00000);
         for (int o = 0; o < 64; o++)
         begin
            cmd(fcp_pkg::FCP_OP_READ, {pg, 6'(o)});
            chk("word", exp_rd(6'(o)), rd_data_o);
         end
      end
      wrap_up();
   end
endmodule : fcp_host_tb_top
